// *** rtc_divider_chain.v ***
// Real time clock: source select, prescalers, prescale timer, calendar
//
// Function
// - Count clock chosen by software from internal sources or external pins.
// - Stages form a chain, each ticked by the previous one's overflow.
// - Divide-by-32 and divide-by-8 prescalers, each bypassable by software.
// - Reloadable 16-bit prescale timer after prescalers feeds calendar counter.
// - 32-bit calendar counter, software reads and writes high and low halves.
// - Calendar made of reloadable 10, 6, 6, 10 bit sub-timers, low first.
// - Every stage only counts up.
// - Each stage may request an interrupt; all merged into one node output.
// - Registers cleared only by power reset, kept through other resets.
// - Prescale timer plus calendar usable as one 48-bit up-counter.
// - Alarm interrupt when chain reaches a software-set point in time.
//
// Behaviour
// A count is taken on an edge with the selected tick and run both high.
// Internal ticks count once per high cycle; hold them one cycle per count.
// Pin sources count rising edges, three cycles after the pin rises.
// Source select may change any time; a pin edge in flight may be lost.
// Prescaler counters hold while bypassed; re-enabling resumes mid-count.
// Every stage overflows at all ones, then loads its reload value.
// Reload values are read at the overflow, so changes apply at the next wrap.
// Stage interrupt enables are sampled at the overflow edge only.
// Software write beats a tick in the same cycle; the tick is lost there.
// Carry out on that cycle still follows the old count.
// A write to either calendar half loads all four sub-timers at once.
// The half not written keeps its value through that load.
// Stopping run freezes every stage; writes still land while stopped.
// Prescale timer and calendar together read as one 48-bit count.
// Reading the two halves at different times can tear across a carry.
// Stage requests reach irq_src two edges after the overflowing tick.
// Alarm pulse lasts one cycle, on the first cycle of equality only.
// Alarm ignores irq_en; alarm_en alone gates it.
// No request is latched here; the node sees each pulse once.
// All pulses and counts are in the clk_sys domain only.
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_divider_chain (
    // Clock and power reset (the only reset the block sees)
    input  wire        clk_sys,
    input  wire        arst_n,
    // Clock source selection
    input  wire [1:0]  src_sel,
    input  wire        int_tick0,
    input  wire        int_tick1,
    input  wire        ext_clk0,
    input  wire        ext_clk1,
    // Chain control
    input  wire        run,
    input  wire        pre32_on,
    input  wire        pre8_on,
    input  wire [15:0] prescale_timer_reload,
    input  wire [31:0] calendar_reload,
    input  wire [4:0]  irq_en,
    // Software access to counters
    input  wire        prescale_timer_wr,
    input  wire [15:0] prescale_timer_wr_data,
    input  wire        calendar_count_high_wr,
    input  wire [15:0] calendar_count_high_wr_data,
    input  wire        calendar_count_low_wr,
    input  wire [15:0] calendar_count_low_wr_data,
    // Alarm
    input  wire        alarm_en,
    input  wire [47:0] alarm_time,
    // Counter views
    output wire [15:0] prescale_timer,
    output wire [15:0] calendar_count_high,
    output wire [15:0] calendar_count_low,
    output wire [47:0] count48,
    // Interrupt requests
    output reg  [5:0]  irq_src,
    output reg         irq_node
);
    // External pins pass two flip-flops, then edge detect on the second
    wire [1:0] ext_pin;
    wire [1:0] ext_rise;
    assign ext_pin = {ext_clk1, ext_clk0};
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_pin
            reg [1:0] sync;
            reg       last;
            // Reset low; a pin idling high gives one count after reset
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    sync <= 2'b00;
                    last <= 1'b0;
                end else begin
                    sync <= {sync[0], ext_pin[p]};
                    last <= sync[1];
                end
            end
            // One-cycle pulse per synced rising edge
            assign ext_rise[p] = sync[1] & ~last;
        end
    endgenerate

    // Source multiplexer
    reg src_tick;
    always @* begin
        case (src_sel)
            `SRC_INT0: src_tick = int_tick0;
            `SRC_INT1: src_tick = int_tick1;
            `SRC_EXT0: src_tick = ext_rise[0];
            `SRC_EXT1: src_tick = ext_rise[1];
            default:   src_tick = 1'b0;
        endcase
    end
    // Run gate, in front of the prescalers
    wire in_tick = src_tick & run;

    // Fixed prescalers, bypassed when switched off
    localparam [5:0] PRE32_TOP = `PRE32_DIV - 6'd1;
    localparam [5:0] PRE8_TOP  = `PRE8_DIV - 6'd1;
    reg  [4:0] pre32_cnt;
    reg  [2:0] pre8_cnt;
    wire       pre32_end  = (pre32_cnt == PRE32_TOP[4:0]);
    wire       pre8_end   = (pre8_cnt == PRE8_TOP[2:0]);
    wire       pre32_tick = pre32_on ? (in_tick & pre32_end) : in_tick;
    wire       pre8_tick  = pre8_on ? (pre32_tick & pre8_end) : pre32_tick;
    // Prescaler counters; they hold while bypassed
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pre32_cnt <= 5'h00;
            pre8_cnt  <= 3'h0;
        end else begin
            if (in_tick & pre32_on)
                pre32_cnt <= pre32_end ? 5'h00 : pre32_cnt + 5'h01;
            if (pre32_tick & pre8_on)
                pre8_cnt <= pre8_end ? 3'h0 : pre8_cnt + 3'h1;
        end
    end

    // Stage chain: prescale timer, then four calendar sub-timers
    wire [4:0]  tick;
    wire [4:0]  carry;
    wire [4:0]  stage_irq;
    wire [31:0] cal;
    wire [31:0] cal_wr_data = {calendar_count_high_wr_data, calendar_count_low_wr_data};
    assign tick = {carry[3:0], pre8_tick};

    // Calendar load word; the half not written keeps its current value
    wire        cal_wr = calendar_count_high_wr | calendar_count_low_wr;
    wire [31:0] cal_load;
    assign cal_load[31:16] = calendar_count_high_wr ? cal_wr_data[31:16] : cal[31:16];
    assign cal_load[15:0]  = calendar_count_low_wr ? cal_wr_data[15:0] : cal[15:0];

    rtc_stage #(.W(`PT_W)) u_prescale (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tick    (tick[0]),
        .reload  (prescale_timer_reload),
        .wr      (prescale_timer_wr),
        .wr_data (prescale_timer_wr_data),
        .irq_en  (irq_en[0]),
        .count   (prescale_timer),
        .carry   (carry[0]),
        .irq_req (stage_irq[0])
    );

    // Calendar sub-timers; a write to either half loads the whole word
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cal
            localparam integer LSB = (g == 0) ? `ST0_LSB : (g == 1) ? `ST1_LSB :
                                     (g == 2) ? `ST2_LSB : `ST3_LSB;
            localparam integer W   = (g == 0) ? `ST0_W : (g == 1) ? `ST1_W :
                                     (g == 2) ? `ST2_W : `ST3_W;
            rtc_stage #(.W(W)) u_sub (
                .clk_sys (clk_sys),
                .arst_n  (arst_n),
                .tick    (tick[g+1]),
                .reload  (calendar_reload[LSB+W-1:LSB]),
                .wr      (cal_wr),
                .wr_data (cal_load[LSB+W-1:LSB]),
                .irq_en  (irq_en[g+1]),
                .count   (cal[LSB+W-1:LSB]),
                .carry   (carry[g+1]),
                .irq_req (stage_irq[g+1])
            );
        end
    endgenerate

    // Half-word views and the 48-bit long counter
    assign calendar_count_high = cal[31:16];
    assign calendar_count_low  = cal[15:0];
    assign count48 = {cal, prescale_timer};

    // Alarm compare, pulse on the cycle the chain reaches the set time
    reg  alarm_hit_last;
    wire alarm_hit = alarm_en & (count48 == alarm_time);
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            alarm_hit_last <= 1'b0;
        else
            alarm_hit_last <= alarm_hit;
    end

    // Rising edge of equality: one-cycle alarm pulse
    wire alarm_pulse = alarm_hit & ~alarm_hit_last;

    // Per-source request lines, registered
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            irq_src <= 6'h00;
        else
            irq_src <= {alarm_pulse, stage_irq};
    end

    // Shared node: OR of the same sources, on the same edge as irq_src
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            irq_node <= 1'b0;
        else
            irq_node <= (|stage_irq) | alarm_pulse;
    end

    // Power reset
    // arst_n is the power reset and the only reset this block sees.
    // Other device resets stay outside, so counts survive them.
endmodule // rtc_divider_chain

// *** rtc_consts.vh ***
// Constants for the real time clock divider chain
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
`define PRE32_DIV      6'd32
`define PRE8_DIV       6'd8
`define PT_W           16
`define ST0_W          10
`define ST1_W          6
`define ST2_W          6
`define ST3_W          10
`define ST0_LSB        0
`define ST1_LSB        10
`define ST2_LSB        16
`define ST3_LSB        22
`define SRC_INT0       2'd0
`define SRC_INT1       2'd1
`define SRC_EXT0       2'd2
`define SRC_EXT1       2'd3
`define CNT_RESET      32'h00000000
`define PT_RESET       16'h0000
`endif

// *** rtc_stage.v ***
// One reloadable up-counting divider stage
`timescale 1ns/1ps
module rtc_stage #(
    parameter W = 16
) (
    // Clock and power reset
    input  wire         clk_sys,
    input  wire         arst_n,
    // Count input and control
    input  wire         tick,
    input  wire [W-1:0] reload,
    input  wire         wr,
    input  wire [W-1:0] wr_data,
    input  wire         irq_en,
    // Results
    output reg  [W-1:0] count,
    output wire         carry,
    output reg          irq_req
);
    // Overflow when at all ones and ticked
    assign carry = tick & (&count);

    // Count up, reload on overflow, software write wins
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count   <= {W{1'b0}};
            irq_req <= 1'b0;
        end else begin
            if (wr)
                count <= wr_data;
            else if (carry)
                count <= reload;
            else if (tick)
                count <= count + {{(W-1){1'b0}}, 1'b1};
            irq_req <= carry & irq_en;
        end
    end
endmodule // rtc_stage

// *** rtc_divider_chain_chk.sv ***
// Checker for the real time clock divider chain
`timescale 1ns/1ps
module rtc_divider_chain_chk (
    // Clock and power reset
    input wire        clk_sys,
    input wire        arst_n,
    // Watched controls
    input wire        run,
    input wire [4:0]  irq_en,
    input wire        prescale_timer_wr,
    input wire        calendar_count_high_wr,
    input wire        calendar_count_low_wr,
    input wire [15:0] calendar_count_low_wr_data,
    // Watched results
    input wire [15:0] prescale_timer,
    input wire [15:0] calendar_count_high,
    input wire [15:0] calendar_count_low,
    input wire [47:0] count48,
    input wire [5:0]  irq_src,
    input wire        irq_node
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Two quiet cycles without software writes
    sequence s_idle;
        (!run && !prescale_timer_wr && !calendar_count_high_wr && !calendar_count_low_wr) [*2];
    endsequence
    // Stage relations
    chk_node_merge: assert property (irq_node == |irq_src)
        else $error("node request differs from stage requests");
    chk_count_pair: assert property (count48 == {calendar_count_high, calendar_count_low, prescale_timer})
        else $error("wide count not made of the halves");
    chk_irq_masked: assert property ((irq_src[4:0] & ~$past(irq_en, 2)) == 5'h00)
        else $error("disabled stage raised a request");
    chk_pt_wrap: assert property (irq_src[0] |-> $past(prescale_timer, 2) == 16'hffff)
        else $error("prescale request without overflow");
    chk_pt_up: assert property (!prescale_timer_wr && prescale_timer != 16'hffff |=>
        prescale_timer == $past(prescale_timer) || prescale_timer == $past(prescale_timer) + 16'h1)
        else $error("prescale timer did not count up");
    chk_alarm_pulse: assert property (irq_src[5] |=> !irq_src[5])
        else $error("alarm request longer than one cycle");
    chk_idle_hold: assert property (s_idle |=> $stable(count48))
        else $error("count moved while stopped");
    chk_low_write: assert property (calendar_count_low_wr |=>
        calendar_count_low == $past(calendar_count_low_wr_data))
        else $error("low half write lost");
endmodule // rtc_divider_chain_chk
bind rtc_divider_chain rtc_divider_chain_chk rtc_divider_chain_chk_inst (
    .clk_sys, .arst_n, .run, .irq_en, .prescale_timer_wr, .calendar_count_high_wr,
    .calendar_count_low_wr, .calendar_count_low_wr_data, .prescale_timer,
    .calendar_count_high, .calendar_count_low, .count48, .irq_src, .irq_node);

// *** test_rtc_divider_chain.sv ***
// Self-checking bench for the real time clock divider chain
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
    err_count = err_count + 1; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_rtc_divider_chain;
    reg         clk_sys, arst_n, run, pre32_on, pre8_on, alarm_en, hw, lw, pw;
    reg  [1:0]  src_sel;
    reg  [3:0]  src;
    reg  [15:0] ptr, pd, hd, ld;
    reg  [31:0] crl;
    reg  [4:0]  ien;
    reg  [47:0] atm;
    wire [15:0] pt, ch, cl;
    wire [47:0] c48;
    wire [5:0]  isrc;
    wire        inode;
    integer     err_count, compares, n_node, i, k;
    reg  [5:0]  seen;
    rtc_divider_chain rtc_divider_chain_inst (.clk_sys, .arst_n, .src_sel, .int_tick0(src[0]),
        .int_tick1(src[1]), .ext_clk0(src[2]), .ext_clk1(src[3]), .run, .pre32_on, .pre8_on,
        .prescale_timer_reload(ptr), .calendar_reload(crl), .irq_en(ien),
        .prescale_timer_wr(pw), .prescale_timer_wr_data(pd), .calendar_count_high_wr(hw),
        .calendar_count_high_wr_data(hd), .calendar_count_low_wr(lw),
        .calendar_count_low_wr_data(ld), .alarm_en, .alarm_time(atm), .prescale_timer(pt),
        .calendar_count_high(ch), .calendar_count_low(cl), .count48(c48), .irq_src(isrc),
        .irq_node(inode));
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Request tallies
    always @(posedge clk_sys) begin
        n_node <= n_node + inode;
        seen <= seen | isrc;
    end
    // Load all three counter registers at once
    task wr(input [47:0] v);
        @(posedge clk_sys);
        {hw, lw, pw} <= 3'h7;
        {hd, ld, pd} <= v;
        @(posedge clk_sys);
        {hw, lw, pw} <= 3'h0;
    endtask
    // n periods of two cycles high, two low on the selected source
    task src_run(input integer n);
        integer j;
        for (j = 0; j < n; j = j + 1) begin
            @(posedge clk_sys) src[src_sel] <= 1'b1;
            repeat (2) @(posedge clk_sys);
            src[src_sel] <= 1'b0;
            @(posedge clk_sys);
        end
        repeat (5) @(posedge clk_sys);
    endtask
    // Full wrap of every stage loads all reload values
    task t_wrap;
        ien <= 5'h1f; crl <= 32'h12345678; ptr <= 16'h0abc; src_sel <= 2'd0;
        wr(48'hffff_ffff_fffe);
        k = n_node;
        src_run(1);
        `CHK("wrap", 48'h1234_5678_0abc, c48)
        `CHK("node", 1, n_node - k)
    endtask
    // Sub-timer field boundary, masked requests, pin source
    task t_carry;
        ien <= 5'h00; crl <= 32'h0; ptr <= 16'h0; src_sel <= 2'd2;
        wr(48'h0000_03ff_ffff);
        k = n_node;
        src_run(1);
        `CHK("carry", 48'h0000_0400_0000, c48)
        `CHK("high", 16'h0000, ch)
        `CHK("low", 16'h0400, cl)
        `CHK("masked", 0, n_node - k)
    endtask
    // Each source alone; pins count one per rising edge
    task t_src;
        for (i = 0; i < 4; i = i + 1) begin
            src_sel <= i[1:0];
            wr(48'h0);
            src_run(3);
            `CHK("source", (i < 2) ? 16'h6 : 16'h3, pt)
        end
    endtask
    // Prescalers: 32, 8 and 256 counts each give exactly one step
    task t_pre;
        src_sel <= 2'd0;
        for (i = 1; i < 4; i = i + 1) begin
            {pre8_on, pre32_on} <= i[1:0];
            k = pt;
            src_run((i == 1) ? 16 : (i == 2) ? 4 : 128);
            `CHK("prescale", k[15:0] + 16'h1, pt)
        end
        {pre8_on, pre32_on} <= 2'b00;
    endtask
    // Stopped chain holds, alarm fires once at the set time
    task t_run_alarm;
        run <= 1'b0;
        wr(48'h0);
        src_run(3);
        `CHK("stopped", 48'h0, c48)
        run <= 1'b1; atm <= 48'h3; alarm_en <= 1'b1;
        k = n_node;
        src_run(2);
        `CHK("alarm", 6'h3f, seen)
        `CHK("alarm once", 1, n_node - k)
    endtask
    // Verdict
    task results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        #400000 err_count = err_count + 1;
        results;
    end
    // Main sequence
    initial begin
        {arst_n, pre32_on, pre8_on, alarm_en, hw, lw, pw, src_sel, src} = 0;
        {ptr, pd, hd, ld, crl, ien, atm} = 0;
        {err_count, compares, n_node, seen, run} = 1;
        {err_count, compares, n_node, seen} = 0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        `CHK("reset", 48'h0, c48)
        t_wrap; t_carry; t_src; t_pre; t_run_alarm;
        arst_n <= 1'b0;
        @(posedge clk_sys);
        `CHK("power", 48'h0, c48)
        results;
    end
endmodule // test_rtc_divider_chain
